// >>> logic/bru_pkg.sv
// Package of opcodes, carriers and reset values for the byte rotate unit
package bru_pkg;

    // ****************************************
    // Opcodes
    // ****************************************
    typedef enum logic [2:0] {
        rotate_left_to_working,
        rotate_left_through_flag_in_place,
        rotate_left_through_flag_to_working,
        rotate_right_in_place,
        rotate_right_to_working,
        rotate_right_through_flag_in_place,
        rotate_right_through_flag_to_working
    } bru_op_e;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic       valid;
        bru_op_e    op;
        logic [7:0] addr;
        logic [7:0] operand;
    } bru_req_s;

    typedef struct packed {
        logic       mem_we;
        logic [7:0] mem_addr;
        logic [7:0] mem_data;
        logic       work_we;
        logic [7:0] work_data;
        logic       flag_we;
    } bru_res_s;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int         BYTE_MSB    = 7;
    localparam logic       FLAG_RESET  = 1'b0;
    localparam logic       STROBE_RESET = 1'b0;
    localparam logic [7:0] BYTE_RESET  = 8'h00;

endpackage : bru_pkg

// >>> logic/bru_rotator.sv
// Combinational one-bit rotator with optional nine-bit path through a flag
`timescale 1ns/1ps
`default_nettype none
module bru_rotator
(
    // Operand and flag
    input  wire logic [7:0] operand,
    input  wire logic       flag_in,
    // Control
    input  wire logic       dir_right,
    input  wire logic       through_flag,
    // Result
    output logic      [7:0] result,
    output logic            flag_out
);

    // ****************************************
    // Rotate
    // ****************************************
    always_comb
    begin
        if (dir_right)
        begin
            result   = {through_flag ? flag_in : operand[0], operand[7:1]};
            flag_out = operand[0];
        end
        else
        begin
            result   = {operand[6:0], through_flag ? flag_in : operand[7]};
            flag_out = operand[7];
        end
    end

endmodule : bru_rotator
`default_nettype wire

// >>> logic/byte_rotate_unit.sv
// Top of the byte rotate unit: decode, rotate and registered write-back
// ****************************************
// Overview of operation
// - Left rotate to working register, bit 7 into bit 0, memory untouched.
// - Nine-bit left rotate through flag, written back to memory.
// - Nine-bit left rotate through flag, result to working register.
// - Right rotate in place, bit 0 into bit 7, flag untouched.
// - Right rotate to working register, memory and flag untouched.
// - Nine-bit right rotate through flag, written back to memory.
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module byte_rotate_unit
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Request from decoder
    input  wire bru_pkg::bru_req_s req,
    // Write-back to memory, working register and flag
    output bru_pkg::bru_res_s      res,
    output logic                   rot_in_out_flag
);

    // ****************************************
    // Decode
    // ****************************************
    logic       dir_right;
    logic       through_flag;
    logic       to_mem;
    logic       uses_flag;
    logic [7:0] rot_result;
    logic       rot_flag;

    always_comb
    begin
        dir_right    = 1'b0;
        through_flag = 1'b0;
        to_mem       = 1'b0;
        uses_flag    = 1'b0;
        case (req.op)
            bru_pkg::rotate_left_to_working:
            begin
                to_mem = 1'b0;
            end
            bru_pkg::rotate_left_through_flag_in_place:
            begin
                through_flag = 1'b1;
                to_mem       = 1'b1;
                uses_flag    = 1'b1;
            end
            bru_pkg::rotate_left_through_flag_to_working:
            begin
                through_flag = 1'b1;
                uses_flag    = 1'b1;
            end
            bru_pkg::rotate_right_in_place:
            begin
                dir_right = 1'b1;
                to_mem    = 1'b1;
            end
            bru_pkg::rotate_right_to_working:
            begin
                dir_right = 1'b1;
            end
            bru_pkg::rotate_right_through_flag_in_place:
            begin
                dir_right    = 1'b1;
                through_flag = 1'b1;
                to_mem       = 1'b1;
                uses_flag    = 1'b1;
            end
            bru_pkg::rotate_right_through_flag_to_working:
            begin
                dir_right    = 1'b1;
                through_flag = 1'b1;
                uses_flag    = 1'b1;
            end
            default:
            begin
                to_mem = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Rotator
    // ****************************************
    bru_rotator u_rot
    (
        .operand      (req.operand),
        .flag_in      (rot_in_out_flag),
        .dir_right    (dir_right),
        .through_flag (through_flag),
        .result       (rot_result),
        .flag_out     (rot_flag)
    );

    // ****************************************
    // Write-back registers
    // ****************************************
    logic       mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_data;
    logic       work_we;
    logic [7:0] work_data;
    logic       flag_we;

    // ****************************************
    // Output
    // ****************************************
    assign res = '{
        mem_we:    mem_we,
        mem_addr:  mem_addr,
        mem_data:  mem_data,
        work_we:   work_we,
        work_data: work_data,
        flag_we:   flag_we
    };

    // ****************************************
    // Memory write strobe
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_we <= bru_pkg::STROBE_RESET;
        end
        else
        begin
            mem_we <= req.valid && to_mem;
        end
    end

    // ****************************************
    // Memory write address
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_addr <= bru_pkg::BYTE_RESET;
        end
        else
        begin
            mem_addr <= req.addr;
        end
    end

    // ****************************************
    // Memory write data
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_data <= bru_pkg::BYTE_RESET;
        end
        else
        begin
            mem_data <= to_mem ? rot_result : bru_pkg::BYTE_RESET;
        end
    end

    // ****************************************
    // Working register strobe
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            work_we <= bru_pkg::STROBE_RESET;
        end
        else
        begin
            work_we <= req.valid && !to_mem;
        end
    end

    // ****************************************
    // Working register data
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            work_data <= bru_pkg::BYTE_RESET;
        end
        else
        begin
            work_data <= to_mem ? bru_pkg::BYTE_RESET : rot_result;
        end
    end

    // ****************************************
    // Flag write strobe
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flag_we <= bru_pkg::STROBE_RESET;
        end
        else
        begin
            flag_we <= req.valid && uses_flag;
        end
    end

    // ****************************************
    // Flag
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rot_in_out_flag <= bru_pkg::FLAG_RESET;
        end
        else if (req.valid && uses_flag)
        begin
            rot_in_out_flag <= rot_flag;
        end
    end

endmodule : byte_rotate_unit
`default_nettype wire

// >>> tb/bru_mem_model.sv
// Data memory and working register fed by the write-back
`timescale 1ns/1ps
`default_nettype none
module bru_mem_model
(
    input wire logic              clk,
    input wire bru_pkg::bru_res_s res
);
    logic [7:0] mem [256];
    logic [7:0] work;
    always_ff @(posedge clk) if (res.mem_we) mem[res.mem_addr] <= res.mem_data;
    always_ff @(posedge clk) if (res.work_we) work <= res.work_data;
endmodule : bru_mem_model
`default_nettype wire

// >>> tb/bru_monitor.sv
// Port checker of the byte rotate unit
`timescale 1ns/1ps
`default_nettype none
module bru_monitor
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire bru_pkg::bru_req_s req,
    input wire bru_pkg::bru_res_s res,
    input wire logic              rot_in_out_flag
);
    logic [7:0] o;
    logic       f;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) o <= req.operand;
    always_ff @(posedge clk) f <= rot_in_out_flag;
    a_left_work:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_left_to_working |=> res.work_we &&
        !res.mem_we && !res.flag_we && res.work_data == {o[6:0], o[7]} &&
        rot_in_out_flag == f) else $error("left to working wrong");
    a_left_flag_mem:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_left_through_flag_in_place |=>
        res.mem_we && !res.work_we && res.flag_we &&
        res.mem_data == {o[6:0], f} && rot_in_out_flag == o[7])
        else $error("left through flag in place wrong");
    a_left_flag_work:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_left_through_flag_to_working |=>
        res.work_we && !res.mem_we && res.flag_we &&
        res.work_data == {o[6:0], f} && rot_in_out_flag == o[7])
        else $error("left through flag to working wrong");
    a_right_mem:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_right_in_place |=>
        res.mem_we && !res.work_we && !res.flag_we &&
        res.mem_data == {o[0], o[7:1]} && rot_in_out_flag == f)
        else $error("right in place wrong");
    a_right_work:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_right_to_working |=>
        res.work_we && !res.mem_we && !res.flag_we &&
        res.work_data == {o[0], o[7:1]} && rot_in_out_flag == f)
        else $error("right to working wrong");
    a_right_flag_mem:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_right_through_flag_in_place |=>
        res.mem_we && !res.work_we && res.flag_we &&
        res.mem_data == {f, o[7:1]} && rot_in_out_flag == o[0])
        else $error("right through flag in place wrong");
    a_right_flag_work:
    assert property (req.valid &&
        req.op == bru_pkg::rotate_right_through_flag_to_working |=>
        res.work_we && !res.mem_we && res.flag_we &&
        res.work_data == {f, o[7:1]} && rot_in_out_flag == o[0])
        else $error("right through flag to working wrong");
    a_addr_follow:
    assert property (req.valid |=> res.mem_addr == $past(req.addr))
        else $error("write-back address wrong");
    a_idle_quiet:
    assert property (!req.valid |=> !res.mem_we && !res.work_we &&
        !res.flag_we) else $error("strobe without request");
    a_flag_with_we:
    assert property ($changed(rot_in_out_flag) |-> res.flag_we ||
        !$past(rst_n)) else $error("flag changed without write strobe");
endmodule : bru_monitor
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench of the byte rotate unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CYCLE_LIMIT = 200;
    localparam bru_pkg::bru_op_e OP_L_WORK =
        bru_pkg::rotate_left_to_working;
    localparam bru_pkg::bru_op_e OP_LF_MEM =
        bru_pkg::rotate_left_through_flag_in_place;
    localparam bru_pkg::bru_op_e OP_LF_WORK =
        bru_pkg::rotate_left_through_flag_to_working;
    localparam bru_pkg::bru_op_e OP_R_MEM =
        bru_pkg::rotate_right_in_place;
    localparam bru_pkg::bru_op_e OP_R_WORK =
        bru_pkg::rotate_right_to_working;
    localparam bru_pkg::bru_op_e OP_RF_MEM =
        bru_pkg::rotate_right_through_flag_in_place;
    localparam bru_pkg::bru_op_e OP_RF_WORK =
        bru_pkg::rotate_right_through_flag_to_working;
    localparam bru_pkg::bru_op_e OP_SPARE =
        bru_pkg::bru_op_e'(3'h7);
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              flag;
    bru_pkg::bru_req_s req = '0;
    bru_pkg::bru_res_s res;
    int                miscompares = 0, tests_run = 0, cyc = 0;
    wire logic [7:0]   strobes = {5'h00, res.mem_we, res.work_we, res.flag_we};
    wire logic [7:0]   flag_byte = {7'h00, flag};
    byte_rotate_unit byte_rotate_unit_i(.clk(clk), .rst_n(rst_n), .req(req),
        .res(res), .rot_in_out_flag(flag));
    bru_mem_model bru_mem_model_i(.clk(clk), .res(res));
    initial forever #5 clk = ~clk;
    task automatic check(string n, logic [7:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic issue(bru_pkg::bru_op_e op, logic [7:0] d, e,
        logic [2:0] w, logic f);
        @(posedge clk) req <= '{1'b1, op, 8'h5a, d};
        @(posedge clk) req.valid <= 1'b0;
        #1;
        check("data", w[2] ? res.mem_data : res.work_data, e);
        check("strobes", strobes, {5'h00, w});
        check("flag", flag_byte, {7'h00, f});
    endtask : issue
    task automatic t_left;
        issue(OP_L_WORK, 8'h81, 8'h03, 3'h2, 1'h0);
        issue(OP_LF_MEM, 8'h81, 8'h02, 3'h5, 1'h1);
        issue(OP_LF_WORK, 8'h40, 8'h81, 3'h3, 1'h0);
        $display("left rotates done");
    endtask : t_left
    task automatic t_right;
        issue(OP_R_MEM, 8'h01, 8'h80, 3'h4, 1'h0);
        issue(OP_RF_MEM, 8'h01, 8'h00, 3'h5, 1'h1);
        issue(OP_RF_MEM, 8'h00, 8'h80, 3'h5, 1'h0);
        issue(OP_R_WORK, 8'h02, 8'h01, 3'h2, 1'h0);
        $display("right rotates done");
    endtask : t_right
    task automatic t_idle;
        @(posedge clk) #1;
        check("strobes", strobes, 8'h00);
        check("memory", bru_mem_model_i.mem[8'h5a], 8'h80);
        check("working", bru_mem_model_i.work, 8'h01);
        $display("idle done");
    endtask : t_idle
    task automatic t_codes;
        issue(OP_RF_WORK, 8'h03, 8'h01, 3'h3, 1'h1);
        issue(OP_SPARE, 8'h81, 8'h03, 3'h2, 1'h1);
        $display("remaining codes done");
    endtask : t_codes
    task automatic t_reset;
        @(posedge clk)
        begin
            req   <= '{1'b1, OP_LF_MEM, 8'h5a, 8'h81};
            rst_n <= 1'b0;
        end
        @(posedge clk)
        begin
            req.valid <= 1'b0;
            rst_n     <= 1'b1;
        end
        #1;
        check("reset strobes", strobes, 8'h00);
        check("reset address", res.mem_addr, 8'h00);
        check("reset flag", flag_byte, 8'h00);
        issue(OP_LF_WORK, 8'h00, 8'h00, 3'h3, 1'h0);
        $display("reset done");
    endtask : t_reset
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == CYCLE_LIMIT)
        begin
            miscompares++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_left;
        t_right;
        t_idle;
        t_codes;
        t_reset;
        wrap_up;
    end
endmodule : tb_top
bind byte_rotate_unit bru_monitor bru_monitor_i(.clk(clk), .rst_n(rst_n),
    .req(req), .res(res), .rot_in_out_flag(rot_in_out_flag));
`default_nettype wire
